/* verilog/i2c_start_defs.svh */
// Purpose: Constants of the start-control block.
// Assumes: 20 MHz reference clock, standard-mode bus timing.
// Notes:   Definitions only; included by bare name.
`ifndef I2C_START_DEFS_SVH
`define I2C_START_DEFS_SVH

// Register offsets (register port, 2-bit address)
`define BUS_CONTROL_0_ADDR      2'h0
`define BUS_FLAG_ADDR           2'h1
`define LINK_STATUS_ADDR        2'h2

// bus_control_0 fields
`define UNIT_ENABLE_BIT         7
`define EXIT_COMM_BIT           6
`define ACK_ENABLE_BIT          2
`define START_TRIGGER_BIT       1
`define STOP_TRIGGER_BIT        0

// bus_flag_register fields
`define START_FAILURE_BIT       7
`define BUS_BUSY_BIT            6
`define RESV_DISABLE_BIT        0

// link status fields
`define MASTER_BIT              7
`define ARB_LOST_BIT            6
`define WAITING_BIT             5
`define RESERVED_PEND_BIT       4

// Reset values
`define BUS_CONTROL_0_RST       8'h00
`define BUS_FLAG_RST            8'h00

// Timing, in ns, and derived cycle counts (least times round up)
`define CLK_PERIOD_NS           50
`define START_HOLD_NS           4000
`define RESTART_SETUP_NS        4700
`define BUS_FREE_NS             4700
`define START_HOLD_CYC   ((`START_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTART_SETUP_CYC ((`RESTART_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_FREE_CYC     ((`BUS_FREE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* verilog/i2c_start_pkg.sv */
// Purpose: Types shared by the start-control block and its helpers.
// Assumes: Constants live in i2c_start_defs.svh.
// Notes:   Nothing here is imported; users write i2c_start_pkg::name.
package i2c_start_pkg;

    // Sampled levels of the two bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } line_t;

    // Byte-engine view of the current acknowledge slot
    typedef struct packed {
        logic ack_slot;
        logic addr_phase;
        logic ext_code;
        logic addr_match;
    } ack_ctx_t;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_RESERVE = 8'h02,
        ST_FREE    = 8'h04,
        ST_START   = 8'h08,
        ST_WAIT    = 8'h10,
        ST_RS_SDA  = 8'h20,
        ST_RS_SCL  = 8'h40,
        ST_RS_SET  = 8'h80
    } start_state_t;

    typedef struct packed {
        start_state_t st;
        logic [7:0]   cnt;
        logic         unit_en;
        logic         ack_en;
        logic         trig;
        logic         resv_dis;
        logic         fail;
        logic         arb_lost;
        logic         master;
        logic         start_oe;
        logic         scl_oe;
        logic         sda_oe;
        logic [7:0]   rdata;
    } ctl_t;

endpackage : i2c_start_pkg

/* verilog/line_sync.sv */
// Purpose: Two-flop synchroniser for the serial clock and data lines.
// Assumes: Lines are asynchronous to ref_clk; both idle high.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module line_sync (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    // Raw and synchronised lines
    input  wire i2c_start_pkg::line_t  raw,
    output var  i2c_start_pkg::line_t  synced
);

    typedef struct packed {
        i2c_start_pkg::line_t meta;
        i2c_start_pkg::line_t stable;
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    always_comb begin
        s_nxt.meta   = raw;
        s_nxt.stable = s_r.meta;
    end

    // Lines idle high, so reset to high to avoid a false start
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign synced = s_r.stable;

endmodule : line_sync

`default_nettype wire

/* verilog/bus_watch.sv */
// Purpose: Detects start and stop conditions and tracks bus occupancy.
// Assumes: Inputs are already synchronised to ref_clk.
// Notes:   While enabled, busy follows any start, own or foreign, until a stop.
`timescale 1ns/1ps
`default_nettype none

module bus_watch (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    // Synchronised lines
    input  wire i2c_start_pkg::line_t  lines,
    input  wire logic                  enable,
    // Conditions
    output logic                       start_det,
    output logic                       stop_det,
    output logic                       busy
);

    typedef struct packed {
        logic sda_d;
        logic start_p;
        logic stop_p;
        logic busy;
    } watch_t;

    watch_t w_r;
    watch_t w_nxt;

    always_comb begin
        w_nxt         = w_r;
        w_nxt.sda_d   = lines.sda;
        w_nxt.start_p = enable && lines.scl && w_r.sda_d && !lines.sda;
        w_nxt.stop_p  = enable && lines.scl && !w_r.sda_d && lines.sda;
        if (!enable || w_nxt.stop_p) begin
            w_nxt.busy = 1'b0;
        end
        if (w_nxt.start_p) begin
            w_nxt.busy = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            w_r <= 4'h8;
        end else begin
            w_r <= w_nxt;
        end
    end

    assign start_det = w_r.start_p;
    assign stop_det  = w_r.stop_p;
    assign busy      = w_r.busy;

endmodule : bus_watch

`default_nettype wire

/* verilog/i2c_start_ctrl.sv */
// Purpose: Start-condition trigger logic of an I2C controller with its register port.
// Assumes: A byte engine elsewhere reports acknowledge slots; lines are open drain.
// Notes:   Output enables high mean the line is pulled low.
//
// Behaviour
// - With the start trigger at 0 no start condition is produced.
// - Trigger set on a released bus pulls data low while clock is high.
// - Clock stays high for the start hold time before it is pulled low.
// - Busy bus, reservation enabled: start deferred until the bus frees.
// - Busy bus, reservation disabled: failure flag set, trigger cleared, no start.
// - Trigger set in master wait releases the wait then issues a repeated start.
// - Losing arbitration clears the start trigger.
// - The trigger clears itself once the start condition has been generated.
// - Writing 1 to exit communication clears the start trigger.
// - Unit enable at 0 holds the start trigger cleared.
// - Unit enable at 0 makes trigger and acknowledge enable inert on the bus.
// - Trigger is bit 1 of control register and always reads back 0.
// - Acknowledge enable is ignored in address transfer and for non-extension codes.
// - A matched slave address is acknowledged whenever the unit is enabled.
// - Reservation disable is flag register bit 0, start failure flag bit 7.
`timescale 1ns/1ps
`default_nettype none

`include "i2c_start_defs.svh"

module i2c_start_ctrl #(
    parameter int HOLD_CYC  = `START_HOLD_CYC,
    parameter int SETUP_CYC = `RESTART_SETUP_CYC,
    parameter int FREE_CYC  = `BUS_FREE_CYC
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    // Register port
    input  wire logic [1:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    // Acknowledge context from the byte engine
    input  wire i2c_start_pkg::ack_ctx_t  ack_ctx,
    // Serial clock line
    input  wire logic                     serial_clock_line_in,
    output logic                          serial_clock_line_out,
    output logic                          serial_clock_line_oe,
    // Serial data line
    input  wire logic                     serial_data_line_in,
    output logic                          serial_data_line_out,
    output logic                          serial_data_line_oe
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (HOLD_CYC < 1 || HOLD_CYC > 255 || SETUP_CYC < 1 || SETUP_CYC > 255 ||
        FREE_CYC < 1 || FREE_CYC > 255) begin : g_bad_timing
        $error("timing counts out of 1..255");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line sampling and bus watch

    i2c_start_pkg::line_t raw_lines;
    i2c_start_pkg::line_t lines;
    logic                 start_det;
    logic                 stop_det;
    logic                 busy;

    assign raw_lines.scl = serial_clock_line_in;
    assign raw_lines.sda = serial_data_line_in;

    line_sync u_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .raw     (raw_lines),
        .synced  (lines)
    );

    i2c_start_pkg::ctl_t c_r;
    i2c_start_pkg::ctl_t c_nxt;

    bus_watch u_watch (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .lines     (lines),
        .enable    (c_r.unit_en),
        .start_det (start_det),
        .stop_det  (stop_det),
        .busy      (busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic wr_hit(input logic [1:0] a);
        wr_hit = reg_wr && (reg_addr == a);
    endfunction : wr_hit

    function automatic logic [7:0] cnt_of(input int n);
        cnt_of = 8'(n - 1);
    endfunction : cnt_of

    logic ctl_wr;
    logic flag_wr;
    logic exit_req;
    logic trig_req;
    logic foreign;
    logic ack_drive;

    always_comb begin
        ctl_wr   = wr_hit(`BUS_CONTROL_0_ADDR);
        flag_wr  = wr_hit(`BUS_FLAG_ADDR);
        exit_req = ctl_wr && reg_wdata[`EXIT_COMM_BIT];
        // A write that also asks for a stop is not taken as a start request
        trig_req = ctl_wr && reg_wdata[`START_TRIGGER_BIT] && !reg_wdata[`STOP_TRIGGER_BIT]
                   && reg_wdata[`UNIT_ENABLE_BIT];
        foreign  = busy && !c_r.master;
        // Matched address acknowledged when unit enabled; enable counts only for extension data
        ack_drive = c_r.unit_en && ack_ctx.ack_slot &&
                    (ack_ctx.addr_match ||
                     (c_r.ack_en && !ack_ctx.addr_phase && ack_ctx.ext_code));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        c_nxt = c_r;

        // Register writes
        if (ctl_wr) begin
            c_nxt.unit_en = reg_wdata[`UNIT_ENABLE_BIT];
            c_nxt.ack_en  = reg_wdata[`ACK_ENABLE_BIT];
        end
        if (flag_wr) begin
            c_nxt.resv_dis = reg_wdata[`RESV_DISABLE_BIT];
        end
        if (trig_req) begin
            c_nxt.trig     = 1'b1;
            c_nxt.fail     = 1'b0;
            c_nxt.arb_lost = 1'b0;
        end

        // A foreign stop ends any mastership we thought we held
        if (stop_det && !c_r.start_oe && !c_r.scl_oe) begin
            c_nxt.master = 1'b0;
        end

        if (c_r.cnt != 8'h00) begin
            c_nxt.cnt = c_r.cnt - 8'h01;
        end

        unique case (c_r.st)
            i2c_start_pkg::ST_IDLE: begin
                c_nxt.start_oe = 1'b0;
                c_nxt.scl_oe   = 1'b0;
                if (c_r.trig) begin
                    if (foreign) begin
                        if (c_r.resv_dis) begin
                            c_nxt.fail = 1'b1;
                            c_nxt.trig = 1'b0;
                        end else begin
                            c_nxt.st = i2c_start_pkg::ST_RESERVE;
                        end
                    end else if (lines.scl && lines.sda) begin
                        c_nxt.start_oe = 1'b1;
                        c_nxt.cnt      = cnt_of(HOLD_CYC);
                        c_nxt.st       = i2c_start_pkg::ST_START;
                    end
                end
            end
            i2c_start_pkg::ST_RESERVE: begin
                if (!busy) begin
                    c_nxt.cnt = cnt_of(FREE_CYC);
                    c_nxt.st  = i2c_start_pkg::ST_FREE;
                end
            end
            i2c_start_pkg::ST_FREE: begin
                // Someone else may grab the bus during the free time
                if (busy) begin
                    c_nxt.st = i2c_start_pkg::ST_RESERVE;
                end else if (c_r.cnt == 8'h00 && lines.scl && lines.sda) begin
                    c_nxt.start_oe = 1'b1;
                    c_nxt.cnt      = cnt_of(HOLD_CYC);
                    c_nxt.st       = i2c_start_pkg::ST_START;
                end
            end
            i2c_start_pkg::ST_START: begin
                c_nxt.start_oe = 1'b1;
                if (c_r.cnt == 8'h00) begin
                    c_nxt.scl_oe = 1'b1;
                    c_nxt.master = 1'b1;
                    c_nxt.trig   = 1'b0;
                    c_nxt.st     = i2c_start_pkg::ST_WAIT;
                end
            end
            i2c_start_pkg::ST_WAIT: begin
                if (c_r.trig) begin
                    // Let data rise while the clock is still held low
                    c_nxt.start_oe = 1'b0;
                    c_nxt.cnt      = cnt_of(SETUP_CYC);
                    c_nxt.st       = i2c_start_pkg::ST_RS_SDA;
                end else if (!c_r.master) begin
                    c_nxt.scl_oe = 1'b0;
                    c_nxt.st     = i2c_start_pkg::ST_IDLE;
                end
            end
            i2c_start_pkg::ST_RS_SDA: begin
                if (c_r.cnt == 8'h00) begin
                    c_nxt.scl_oe = 1'b0;
                    c_nxt.st     = i2c_start_pkg::ST_RS_SCL;
                end
            end
            i2c_start_pkg::ST_RS_SCL: begin
                // A slave may stretch the clock; wait for it to read high
                if (lines.scl) begin
                    c_nxt.cnt = cnt_of(SETUP_CYC);
                    c_nxt.st  = i2c_start_pkg::ST_RS_SET;
                end
            end
            i2c_start_pkg::ST_RS_SET: begin
                if (!lines.sda) begin
                    c_nxt.arb_lost = 1'b1;
                    c_nxt.trig     = 1'b0;
                    c_nxt.master   = 1'b0;
                    c_nxt.st       = i2c_start_pkg::ST_IDLE;
                end else if (c_r.cnt == 8'h00) begin
                    c_nxt.start_oe = 1'b1;
                    c_nxt.cnt      = cnt_of(HOLD_CYC);
                    c_nxt.st       = i2c_start_pkg::ST_START;
                end
            end
        endcase

        // Leaving communication drops the start and clock drives; an acknowledge drive stays
        if (exit_req) begin
            c_nxt.trig     = 1'b0;
            c_nxt.master   = 1'b0;
            c_nxt.start_oe = 1'b0;
            c_nxt.scl_oe   = 1'b0;
            c_nxt.st       = i2c_start_pkg::ST_IDLE;
        end

        // Disabled unit: nothing may reach the bus
        if (!c_nxt.unit_en) begin
            c_nxt.trig     = 1'b0;
            c_nxt.fail     = 1'b0;
            c_nxt.master   = 1'b0;
            c_nxt.start_oe = 1'b0;
            c_nxt.scl_oe   = 1'b0;
            c_nxt.st       = i2c_start_pkg::ST_IDLE;
        end

        c_nxt.sda_oe = c_nxt.start_oe || ack_drive;

        // Read data, valid the cycle after the strobe
        c_nxt.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `BUS_CONTROL_0_ADDR: begin
                    // Trigger and self-clearing bits always read as zero
                    c_nxt.rdata[`UNIT_ENABLE_BIT] = c_r.unit_en;
                    c_nxt.rdata[`ACK_ENABLE_BIT]  = c_r.ack_en;
                end
                `BUS_FLAG_ADDR: begin
                    c_nxt.rdata[`START_FAILURE_BIT] = c_r.fail;
                    c_nxt.rdata[`BUS_BUSY_BIT]      = busy;
                    c_nxt.rdata[`RESV_DISABLE_BIT]  = c_r.resv_dis;
                end
                `LINK_STATUS_ADDR: begin
                    c_nxt.rdata[`MASTER_BIT]        = c_r.master;
                    c_nxt.rdata[`ARB_LOST_BIT]      = c_r.arb_lost;
                    c_nxt.rdata[`WAITING_BIT]       = (c_r.st == i2c_start_pkg::ST_WAIT);
                    c_nxt.rdata[`RESERVED_PEND_BIT] =
                        (c_r.st == i2c_start_pkg::ST_RESERVE) ||
                        (c_r.st == i2c_start_pkg::ST_FREE);
                end
                default: begin
                    c_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            c_r          <= '0;
            c_r.st       <= i2c_start_pkg::ST_IDLE;
            c_r.unit_en  <= 1'(`BUS_CONTROL_0_RST >> `UNIT_ENABLE_BIT);
            c_r.trig     <= 1'b0;
            c_r.resv_dis <= 1'(`BUS_FLAG_RST >> `RESV_DISABLE_BIT);
        end else begin
            c_r <= c_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs (open drain: only ever pull low)

    logic scl_low_r;
    logic sda_low_r;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else begin
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
        end
    end

    assign reg_rdata             = c_r.rdata;
    assign serial_clock_line_out = scl_low_r;
    assign serial_clock_line_oe  = c_r.scl_oe;
    assign serial_data_line_out  = sda_low_r;
    assign serial_data_line_oe   = c_r.sda_oe;

endmodule : i2c_start_ctrl

`default_nettype wire

/* test/i2c_start_ctrl_properties.sv */
// Purpose: Port-level assertions for the start-control block.
// Assumes: Output enables high pull a line low.
// Notes:   Unit enable is tracked from register writes.
`timescale 1ns/1ps
`default_nettype none
module i2c_start_ctrl_properties #(
    parameter int HOLD_CYC = 80
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Byte engine and lines
    input wire i2c_start_pkg::ack_ctx_t ack_ctx,
    input wire logic serial_clock_line_in,
    input wire logic serial_clock_line_out,
    input wire logic serial_clock_line_oe,
    input wire logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic       en_r;
    logic [7:0] sda_cnt_r;
    // Run length of data pulled low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_r <= 1'b0;
            sda_cnt_r <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == 2'h0) begin
                en_r <= reg_wdata[7];
            end
            if (!serial_data_line_oe) begin
                sda_cnt_r <= 8'h00;
            end else if (sda_cnt_r != 8'hff) begin
                sda_cnt_r <= sda_cnt_r + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_open_drain;
        !serial_clock_line_out && !serial_data_line_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_start_shape;
        $rose(serial_data_line_oe) && !serial_clock_line_oe && !$past(ack_ctx.ack_slot)
            |-> serial_clock_line_in;
    endproperty
    a_start_shape: assert property (p_start_shape) else $error("start shape");
    property p_hold;
        $rose(serial_clock_line_oe) |-> int'(sda_cnt_r) >= HOLD_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("hold short");
    property p_rd_fields;
        reg_rd && reg_addr == 2'h0 |=> reg_rdata[1:0] == 2'h0 && !reg_rdata[6];
    endproperty
    a_rd_fields: assert property (p_rd_fields) else $error("bit read 1");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_disabled;
        !en_r |=> !serial_data_line_oe && !serial_clock_line_oe;
    endproperty
    a_disabled: assert property (p_disabled) else $error("bus driven while off");
    property p_exit;
        reg_wr && reg_addr == 2'h0 && reg_wdata[6] && !ack_ctx.ack_slot
            |-> ##2 !serial_data_line_oe && !serial_clock_line_oe;
    endproperty
    a_exit: assert property (p_exit) else $error("lines held after exit");
    property p_ack_match;
        ack_ctx.ack_slot && ack_ctx.addr_match && en_r |=> serial_data_line_oe;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("match not acked");
    c_start: cover property ($rose(serial_clock_line_oe));
    c_restart: cover property ($fell(serial_data_line_oe) && serial_clock_line_oe);
    c_flag_read: cover property (reg_rd && reg_addr == 2'h1);
endmodule : i2c_start_ctrl_properties
bind i2c_start_ctrl i2c_start_ctrl_properties #(.HOLD_CYC(HOLD_CYC)) u_props (.*);
`default_nettype wire

/* test/i2c_far_peer.sv */
// Purpose: Another master on the bus, driven by bench calls.
// Assumes: Lines have pull-ups; enables high pull low.
// Notes:   Clock moves only inside its own frames.
`timescale 1ns/1ps
`default_nettype none
module i2c_far_peer (
    // Wire levels
    input  wire logic scl,
    input  wire logic sda,
    // Pull-down enables
    output var  logic scl_oe,
    output var  logic sda_oe
);
    localparam time HALF = 200ns;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // Start, then keep the bus with clock low
    task automatic start_seq();
        sda_oe = 1'b1;
        #HALF;
        scl_oe = 1'b1;
        #HALF;
    endtask : start_seq
    // Clock may be stretched, so await it
    task automatic stop_seq();
        sda_oe = 1'b1;
        #HALF;
        scl_oe = 1'b0;
        wait (scl === 1'b1);
        #HALF;
        sda_oe = 1'b0;
        #HALF;
    endtask : stop_seq
    task automatic grab_sda();
        sda_oe = 1'b1;
    endtask : grab_sda
endmodule : i2c_far_peer
`default_nettype wire

/* test/tb_top.sv */
// Purpose: Self-checking bench of the start-control block.
// Assumes: Shortened hold, setup and bus-free counts.
// Notes:   A peer model plays the other masters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int HOLD = 4;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    i2c_start_pkg::ack_ctx_t ack_ctx = '0;
    logic scl_out, scl_oe, sda_out, sda_oe, p_scl_oe, p_sda_oe;
    wire logic scl = !(scl_oe || p_scl_oe);
    wire logic sda = !(sda_oe || p_sda_oe);
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    i2c_start_ctrl #(.HOLD_CYC(HOLD), .SETUP_CYC(4), .FREE_CYC(4)) u_dut (
        .ref_clk, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .ack_ctx,
        .serial_clock_line_in(scl), .serial_clock_line_out(scl_out),
        .serial_clock_line_oe(scl_oe), .serial_data_line_in(sda),
        .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe));
    i2c_far_peer u_peer (.scl, .sda, .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] mask,
                      input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata & mask);
    endtask : rd
    task automatic wait_oe(input bit clk_sel, input logic lvl, output int n);
        for (n = 1; n <= 400; n++) begin
            @(posedge ref_clk);
            #1;
            if ((clk_sel ? scl_oe : sda_oe) === lvl) break;
        end
        check("line enable", {7'h00, lvl}, {7'h00, clk_sel ? scl_oe : sda_oe});
    endtask : wait_oe
    task automatic ack(input logic [3:0] ctx, input logic exp);
        @(posedge ref_clk);
        ack_ctx <= i2c_start_pkg::ack_ctx_t'(ctx);
        @(posedge ref_clk);
        ack_ctx <= '0;
        #1;
        check("ack drive", {7'h00, exp}, {7'h00, sda_oe});
    endtask : ack
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_enable();
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00, 8'hff, "unmapped read");
        rd(2'h0, 8'h00, 8'hff, "reset control");
        rd(2'h1, 8'h00, 8'hff, "reset flags");
        wr(2'h0, 8'h06);
        ack(4'b1010, 1'b0);
        wr(2'h0, 8'h83);
        repeat (10) @(posedge ref_clk);
        rd(2'h0, 8'h80, 8'hff, "paired triggers");
        check("no start", 8'h00, {7'h00, sda_oe});
        wr(2'h0, 8'h84);
        ack(4'b1010, 1'b1);
        ack(4'b1110, 1'b0);
        ack(4'b1000, 1'b0);
        wr(2'h0, 8'h80);
        ack(4'b1101, 1'b1);
        u_peer.stop_seq();
    endtask : t_enable
    task automatic t_start();
        int n;
        wr(2'h0, 8'h82);
        wait_oe(1'b0, 1'b1, n);
        check("start clock", 8'h01, {7'h00, scl});
        wait_oe(1'b1, 1'b1, n);
        check("start hold", 8'(HOLD), 8'(n));
        rd(2'h0, 8'h80, 8'hff, "start trigger");
        rd(2'h2, 8'h80, 8'h80, "start master");
    endtask : t_start
    task automatic t_exit();
        wr(2'h0, 8'hc0);
        repeat (2) @(posedge ref_clk);
        #1;
        check("exit enables", 8'h00, {6'h00, scl_oe, sda_oe});
        rd(2'h2, 8'h00, 8'h80, "exit master");
        u_peer.stop_seq();
    endtask : t_exit
    task automatic t_reserve();
        int n;
        wr(2'h1, 8'h00);
        u_peer.start_seq();
        wr(2'h0, 8'h82);
        repeat (20) @(posedge ref_clk);
        check("start while busy", 8'h00, {7'h00, sda_oe});
        u_peer.stop_seq();
        wait_oe(1'b0, 1'b1, n);
        wait_oe(1'b1, 1'b1, n);
        rd(2'h0, 8'h80, 8'hff, "reserved trigger");
        t_exit();
    endtask : t_reserve
    task automatic t_refuse();
        wr(2'h1, 8'h01);
        u_peer.start_seq();
        wr(2'h0, 8'h82);
        repeat (10) @(posedge ref_clk);
        rd(2'h1, 8'hc1, 8'hff, "refusal flags");
        rd(2'h0, 8'h80, 8'hff, "refused trigger");
        u_peer.stop_seq();
        repeat (30) @(posedge ref_clk);
        check("late start", 8'h00, {7'h00, sda_oe});
        wr(2'h1, 8'h00);
    endtask : t_refuse
    task automatic t_restart();
        int n;
        t_start();
        wr(2'h0, 8'h82);
        wait_oe(1'b0, 1'b0, n);
        wait_oe(1'b1, 1'b0, n);
        wait_oe(1'b0, 1'b1, n);
        check("restart clock", 8'h01, {7'h00, scl});
        wait_oe(1'b1, 1'b1, n);
        check("restart hold", 8'(HOLD), 8'(n));
        rd(2'h0, 8'h80, 8'hff, "restart trigger");
    endtask : t_restart
    task automatic t_arb();
        int n;
        wr(2'h0, 8'h82);
        wait_oe(1'b1, 1'b0, n);
        u_peer.grab_sda();
        repeat (20) @(posedge ref_clk);
        rd(2'h2, 8'h40, 8'hc0, "loss status");
        rd(2'h0, 8'h80, 8'hff, "loss trigger");
        t_exit();
    endtask : t_arb
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_enable();
        t_start();
        t_exit();
        t_reserve();
        t_refuse();
        t_restart();
        t_arb();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
